// ### logic/boot_unlock_window.sv
`default_nettype none
module boot_unlock_window
    import isp_boot_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // key write
    input wire logic key_write,
    input wire logic [7:0] key_data,
    // emulation hold
    input wire logic freeze,
    // state
    output logic unlock_active,
    output logic [3:0] count
);
    logic [3:0] next_count;
    wire key_match = key_data[7:KEY_LSB] == UNLOCK_KEY;

    // interrupts never enter here, so the window keeps running
    assign next_count = key_write ? (key_match ? UNLOCK_CYCLES : 4'h0)
        : (count != 4'h0 && !freeze) ? count - 4'h1
        : count;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 4'h0;
            unlock_active <= 1'b0;
        end else begin
            count <= next_count;
            unlock_active <= next_count != 4'h0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_key_set;
        key_write && key_match |=> unlock_active && count == UNLOCK_CYCLES;
    endproperty
    a_key_set: assert property (p_key_set)
        else $error("matching key did not open window");

    property p_key_bad;
        key_write && !key_match |=> !unlock_active;
    endproperty
    a_key_bad: assert property (p_key_bad)
        else $error("wrong key opened window");

    property p_expire;
        count == 4'h1 && !freeze && !key_write |=> !unlock_active;
    endproperty
    a_expire: assert property (p_expire)
        else $error("unlock did not expire");

    property p_freeze;
        unlock_active && freeze && !key_write |=> unlock_active
            && count == $past(count);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("unlock counter moved during breakpoint");

    c_window: cover property (key_write && key_match ##1 unlock_active[*8]
        ##1 !unlock_active);
endmodule
`default_nettype wire

// ### logic/isp_boot_entry_control.sv
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
module isp_boot_entry_control
    import isp_boot_pkg::*;
#(
    parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
    parameter int LOAD_HALF = LOAD_CLK_HALF
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // cpu side
    input wire logic jump_to_boot_instr,
    input wire logic return_to_flash_instr,
    input wire logic emulation_mode,
    input wire logic breakpoint_hit,
    output logic exec_in_boot_rom,
    output logic jump_to_boot_taken,
    output logic jump_to_flash_taken,
    // option bits and erase commands
    input wire logic boot_select,
    input wire logic mass_erase_cmd,
    input wire logic user_isp_active,
    output logic security_clear_allowed,
    // flash engine
    input wire logic flash_op_start,
    input wire logic flash_busy,
    output logic flash_timing_pulse,
    output logic [7:0] flash_pulse_timing_out,
    output logic [7:0] isp_write_data_out,
    output logic flash_fetch_block,
    // forced boot and serial pins
    input wire logic forced_boot_hv,
    input wire logic forced_boot_pin_in,
    output logic forced_boot_pin_read,
    output logic serial_clock_out,
    output logic serial_clock_oe,
    output logic isp_cmd_enable
);
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = a == ADDR_W'(off);
    endfunction

    // registers
    logic [7:0] isp_write_data;
    logic [7:0] flash_pulse_timing;
    exec_state_t state;
    logic forced_mode;
    logic hv_in_reset;
    logic unlock_active;
    logic [3:0] unlock_count;
    logic pin_released;

    // axi write path
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wlane0_q;
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire do_write = aw_held && w_held && !bvalid;
    wire next_aw_held = (aw_held || aw_take) && !do_write;
    wire next_w_held = (w_held || w_take) && !do_write;
    wire wr_data_reg = hit(awaddr_q, OFF_WRITE_DATA);
    wire wr_timing_reg = hit(awaddr_q, OFF_PULSE_TIMING);
    wire wr_key_reg = hit(awaddr_q, OFF_UNLOCK_CODE);
    wire wr_status_reg = hit(awaddr_q, OFF_STATUS);
    wire wr_mapped = wr_data_reg || wr_timing_reg || wr_key_reg
        || wr_status_reg;
    wire key_write = do_write && wr_key_reg && wlane0_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wlane0_q <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            awready <= !next_aw_held;
            wready <= !next_w_held;
            if (aw_take) begin
                awaddr_q <= awaddr;
            end
            if (w_take) begin
                wdata_q <= wdata[7:0];
                wlane0_q <= wstrb[0];
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            isp_write_data <= WRITE_DATA_RESET;
            flash_pulse_timing <= PULSE_TIMING_RESET;
        end else if (do_write && wlane0_q) begin
            if (wr_data_reg) begin
                isp_write_data <= wdata_q;
            end
            if (wr_timing_reg) begin
                flash_pulse_timing <= {1'b0, wdata_q[6:0]};
            end
        end
    end

    // axi read path
    logic [31:0] status_word;
    logic [31:0] read_word;
    wire ar_take = arvalid && arready;
    wire rd_mapped = hit(araddr, OFF_WRITE_DATA)
        || hit(araddr, OFF_PULSE_TIMING) || hit(araddr, OFF_UNLOCK_CODE)
        || hit(araddr, OFF_STATUS);
    wire next_rvalid = ar_take || (rvalid && !rready);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_UNLOCK] = unlock_active;
        status_word[ST_BOOT_ROM] = exec_in_boot_rom;
        status_word[ST_FORCED] = forced_mode;
        status_word[ST_CMD_EN] = isp_cmd_enable;
    end

    assign read_word = hit(araddr, OFF_WRITE_DATA) ? {24'h00_0000,
            isp_write_data}
        : hit(araddr, OFF_PULSE_TIMING) ? {24'h00_0000, flash_pulse_timing}
        : hit(araddr, OFF_STATUS) ? status_word
        : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            arready <= !next_rvalid;
            rvalid <= next_rvalid;
            if (ar_take) begin
                rdata <= read_word;
                rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // unlock window
    boot_unlock_window u_unlock (
        .aclk(aclk),
        .aresetn(aresetn),
        .key_write(key_write),
        .key_data(wdata_q),
        .freeze(emulation_mode && breakpoint_hit),
        .unlock_active(unlock_active),
        .count(unlock_count)
    );

    // high voltage seen while reset is held
    always_ff @(posedge aclk) begin
        hv_in_reset <= aresetn ? hv_in_reset : forced_boot_hv;
    end

    // execution location
    wire boot_rom_at_start = hv_in_reset || !boot_select;
    wire jump_to_boot_instr_boot = jump_to_boot_instr && unlock_active;
    wire jump_to_boot_instr_flash = jump_to_boot_instr && !unlock_active;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= st_start;
            forced_mode <= 1'b0;
            exec_in_boot_rom <= 1'b0;
            jump_to_boot_taken <= 1'b0;
            jump_to_flash_taken <= 1'b0;
        end else begin
            jump_to_boot_taken <= 1'b0;
            jump_to_flash_taken <= 1'b0;
            unique case (state)
                st_start: begin
                    // plain resets fall back to the option bit
                    forced_mode <= hv_in_reset;
                    exec_in_boot_rom <= boot_rom_at_start;
                    state <= boot_rom_at_start ? st_boot : st_flash;
                end
                st_flash: begin
                    if (jump_to_boot_instr_boot) begin
                        state <= st_boot;
                        exec_in_boot_rom <= 1'b1;
                        jump_to_boot_taken <= 1'b1;
                    end else if (jump_to_boot_instr_flash) begin
                        jump_to_flash_taken <= 1'b1;
                    end
                end
                st_boot: begin
                    if (return_to_flash_instr) begin
                        state <= st_flash;
                        exec_in_boot_rom <= 1'b0;
                    end
                end
            endcase
        end
    end

    // flash pulse generator and fetch guard
    logic [6:0] pulse_count;
    wire pulse_start = flash_op_start && pulse_count == 7'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_count <= 7'h00;
            flash_timing_pulse <= 1'b0;
            flash_fetch_block <= 1'b0;
            flash_pulse_timing_out <= PULSE_TIMING_RESET;
            isp_write_data_out <= WRITE_DATA_RESET;
            security_clear_allowed <= 1'b0;
        end else begin
            if (pulse_start) begin
                pulse_count <= flash_pulse_timing[6:0];
                flash_timing_pulse <= flash_pulse_timing[6:0] != 7'h00;
            end else if (pulse_count != 7'h00) begin
                pulse_count <= pulse_count - 7'h01;
                flash_timing_pulse <= pulse_count != 7'h01;
            end
            flash_fetch_block <= flash_busy && !exec_in_boot_rom;
            flash_pulse_timing_out <= flash_pulse_timing;
            isp_write_data_out <= isp_write_data;
            // forced entry has no path to option bits
            security_clear_allowed <= mass_erase_cmd || user_isp_active;
        end
    end

    // forced boot pin handling
    localparam int LDW = $clog2(LOAD_HALF + 1);
    logic [LDW-1:0] load_div;
    logic settled_low;

    always_ff @(posedge aclk) begin
        if (!aresetn || !forced_boot_hv) begin
            load_div <= '0;
            serial_clock_out <= 1'b0;
        end else if (load_div == LDW'(LOAD_HALF - 1)) begin
            load_div <= '0;
            serial_clock_out <= !serial_clock_out;
        end else begin
            load_div <= load_div + LDW'(1);
        end
    end

    pin_low_debounce #(
        .CYCLES(DEB_CYCLES)
    ) u_debounce (
        .aclk(aclk),
        .aresetn(aresetn),
        .arm(forced_mode),
        .pin_high(forced_boot_pin_in || forced_boot_hv),
        .settled_low(settled_low)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_clock_oe <= 1'b0;
            forced_boot_pin_read <= 1'b0;
            pin_released <= 1'b0;
            isp_cmd_enable <= 1'b0;
        end else begin
            serial_clock_oe <= forced_boot_hv;
            forced_boot_pin_read <= forced_boot_hv || forced_boot_pin_in;
            pin_released <= pin_released || settled_low;
            isp_cmd_enable <= exec_in_boot_rom
                && (!forced_mode || pin_released || settled_low);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_reset_timing;
        $rose(aresetn) |-> flash_pulse_timing == PULSE_TIMING_RESET;
    endproperty
    a_reset_timing: assert property (p_reset_timing)
        else $error("pulse timing not preset");

    property p_bit7;
        flash_pulse_timing[7] == 1'b0;
    endproperty
    a_bit7: assert property (p_bit7)
        else $error("pulse timing bit 7 became set");

    property p_jump_to_boot_instr_boot;
        state == st_flash && jump_to_boot_instr && unlock_active
            |=> exec_in_boot_rom && jump_to_boot_taken;
    endproperty
    a_jump_to_boot_instr_boot: assert property (p_jump_to_boot_instr_boot)
        else $error("unlocked jump did not enter boot rom");

    property p_jump_to_boot_instr_flash;
        state == st_flash && jump_to_boot_instr && !unlock_active
            |=> !exec_in_boot_rom && jump_to_flash_taken;
    endproperty
    a_jump_to_boot_instr_flash: assert property (p_jump_to_boot_instr_flash)
        else $error("locked jump entered boot rom");

    property p_fetch_block;
        flash_busy && !exec_in_boot_rom |=> flash_fetch_block;
    endproperty
    a_fetch_block: assert property (p_fetch_block)
        else $error("flash fetch not blocked while busy");

    property p_pulse_width;
        pulse_start && flash_pulse_timing[6:0] == 7'h02
            |=> flash_timing_pulse ##1 flash_timing_pulse ##1
            !flash_timing_pulse;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("pulse width does not follow timing value");

    property p_start_select;
        aresetn && state == st_start |=> exec_in_boot_rom ==
            ($past(hv_in_reset) || !$past(boot_select));
    endproperty
    a_start_select: assert property (p_start_select)
        else $error("wrong start memory after reset");

    property p_hv_pins;
        aresetn && forced_boot_hv |=> forced_boot_pin_read && serial_clock_oe;
    endproperty
    a_hv_pins: assert property (p_hv_pins)
        else $error("high voltage did not drive load clock");

    c_unlock_jump: cover property (key_write ##[1:8] jump_to_boot_instr_boot);
    c_forced: cover property (state == st_start && hv_in_reset
        ##[1:1000] isp_cmd_enable);
    c_return: cover property (state == st_boot && return_to_flash_instr);
endmodule
`default_nettype wire

// ### logic/isp_boot_pkg.sv
// Contract
// - pulse-timing value sets flash pulse width
// - reset presets pulse timing for 10 MHz
// - fixed band codes; bit 7 read-only
// - no flash fetch while flash programs
// - jump-to-boot enters boot only when unlocked
// - compare bits 7..2 against 100110 only
// - unlock register is memory mapped
// - breakpoint in emulation freezes unlock counter
// - interrupts do not stop unlock countdown
// - high voltage in reset forces boot start
// - later plain reset follows boot-select bit
// - forced entry keeps option and security bits
// - high voltage drives load clock, reads one
// - command handler waits for debounced pin low
// - boot-select 0 boots ROM, 1 boots flash
`default_nettype none
package isp_boot_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int DEBOUNCE_TIME_NS = 20000;
    localparam int DEBOUNCE_CYCLES =
        (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOAD_CLK_HALF = 4;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_WRITE_DATA = 8'h00;
    localparam logic [7:0] OFF_PULSE_TIMING = 8'h04;
    localparam logic [7:0] OFF_UNLOCK_CODE = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] PULSE_TIMING_RESET = 8'h7b;
    localparam logic [7:0] WRITE_DATA_RESET = 8'h00;
    localparam logic [5:0] UNLOCK_KEY = 6'h26;
    localparam int KEY_LSB = 2;
    localparam logic [3:0] UNLOCK_CYCLES = 4'h8;
    localparam int ST_UNLOCK = 0;
    localparam int ST_BOOT_ROM = 1;
    localparam int ST_FORCED = 2;
    localparam int ST_CMD_EN = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        st_start = 3'b001,
        st_flash = 3'b010,
        st_boot = 3'b100
    } exec_state_t;
endpackage
`default_nettype wire

// ### logic/pin_low_debounce.sv
`default_nettype none
module pin_low_debounce
    import isp_boot_pkg::*;
#(
    parameter int CYCLES = DEBOUNCE_CYCLES
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pin
    input wire logic arm,
    input wire logic pin_high,
    // result
    output logic settled_low
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);
    logic [CW-1:0] run;

    always_ff @(posedge aclk) begin
        if (!aresetn || !arm || pin_high) begin
            run <= '0;
        end else if (run != LAST) begin
            run <= run + CW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !arm) begin
            settled_low <= 1'b0;
        end else if (run == LAST && !pin_high) begin
            settled_low <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_settle;
        $rose(settled_low) |-> !$past(pin_high) && $past(run) == LAST;
    endproperty
    a_settle: assert property (p_settle)
        else $error("pin released without debounce");
endmodule
`default_nettype wire

// ### test/hv_programmer.sv
`default_nettype none
module hv_programmer #(
    parameter int HOLD = 4
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request from bench
    input wire logic apply,
    // forced-boot pin
    output logic hv,
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    int n;
    initial begin
        hv = 1'b0;
        pin_level = 1'b0;
        n = 0;
    end
    // raise only while reset is low, drop only after the hold
    always @(posedge aclk) begin
        if (!aresetn && apply) begin
            hv <= 1'b1;
            pin_level <= 1'b1;
            n <= 0;
        end else if (hv && aresetn) begin
            n <= n + 1;
            if (n >= HOLD && !apply) begin
                hv <= 1'b0;
                pin_level <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/tb_isp_boot_entry_control.sv
`default_nettype none
module tb_isp_boot_entry_control
    import isp_boot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEB = 8;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic jump_to_boot_instr, return_to_flash_instr, emulation_mode;
    logic breakpoint_hit, exec_in_boot_rom, jump_to_boot_taken;
    logic jump_to_flash_taken, boot_select, mass_erase_cmd;
    logic user_isp_active, security_clear_allowed, flash_op_start;
    logic flash_busy, flash_timing_pulse, flash_fetch_block;
    logic [7:0] flash_pulse_timing_out, isp_write_data_out;
    logic forced_boot_hv, forced_boot_pin_in, forced_boot_pin_read;
    logic serial_clock_out, serial_clock_oe, isp_cmd_enable, hv_req;
    int n_mismatch, total_checks, k;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] v, e;

    isp_boot_entry_control #(.DEB_CYCLES(DEB), .LOAD_HALF(4)) u_dut (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp,
        .jump_to_boot_instr, .return_to_flash_instr, .emulation_mode,
        .breakpoint_hit, .exec_in_boot_rom, .jump_to_boot_taken,
        .jump_to_flash_taken, .boot_select, .mass_erase_cmd,
        .user_isp_active, .security_clear_allowed, .flash_op_start,
        .flash_busy, .flash_timing_pulse, .flash_pulse_timing_out,
        .isp_write_data_out, .flash_fetch_block, .forced_boot_hv,
        .forced_boot_pin_in, .forced_boot_pin_read, .serial_clock_out,
        .serial_clock_oe, .isp_cmd_enable);
    hv_programmer #(.HOLD(4)) u_host (.aclk(aclk), .aresetn(aresetn),
        .apply(hv_req), .hv(forced_boot_hv), .pin_level(forced_boot_pin_in));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] dt, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= dt;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        rs = bresp;
        bready <= 1'b0;
        if (n == 50) chk("write timeout", 1, 0);
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] dt,
                      output logic [1:0] rs);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        dt = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (n == 50) chk("read timeout", 1, 0);
    endtask
    task automatic do_reset(logic hv);
        @(posedge aclk);
        aresetn <= 1'b0; hv_req <= hv;
        cyc(8);
        aresetn <= 1'b1;
        cyc(2);
        hv_req <= 1'b0;
    endtask
    task automatic jump(logic boot);
        @(posedge aclk) jump_to_boot_instr <= 1'b1;
        @(posedge aclk) jump_to_boot_instr <= 1'b0;
        #1;
        chk("boot taken", boot, jump_to_boot_taken);
        chk("flash taken", !boot, jump_to_flash_taken);
        chk("in boot rom", boot, exec_in_boot_rom);
    endtask
    task automatic tdone(string nm);
        $display("test %s done", nm);
    endtask

    initial begin
        #(40 * 20000);
        n_mismatch++;
        finish_test();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awprot, arprot} = '0;
        {awaddr, araddr, wdata, hv_req, flash_op_start, flash_busy} = '0;
        {jump_to_boot_instr, return_to_flash_instr, emulation_mode} = '0;
        {breakpoint_hit, mass_erase_cmd, user_isp_active} = '0;
        wstrb = 4'hf;
        boot_select = 1'b1;
        aresetn = 1'b0;
        n_mismatch = 0;
        total_checks = 0;
        v = $urandom(2483);
        do_reset(1'b0);
        rd(OFF_PULSE_TIMING, d, r);
        chk("timing reset", 32'h0000_007b, d);
        chk("read resp", RESP_OKAY, r);
        rd(OFF_STATUS, d, r);
        chk("flash start", 0, d[ST_BOOT_ROM]);
        tdone("reset");
        for (k = 0; k < 4; k++) begin
            v = $urandom;
            v[6:0] = 7'(v % 127 + 1);
            if (k < 2) v[6:0] = k ? 7'h7f : 7'h02;
            wr(OFF_PULSE_TIMING, {24'h0, v}, r);
            chk("timing resp", RESP_OKAY, r);
            rd(OFF_PULSE_TIMING, d, r);
            chk("timing rd", {25'h0, v[6:0]}, d);
            chk("timing out", {1'b0, v[6:0]}, flash_pulse_timing_out);
            @(posedge aclk) flash_op_start <= 1'b1;
            @(posedge aclk) flash_op_start <= 1'b0;
            d = 0;
            repeat (140) @(posedge aclk) d += flash_timing_pulse;
            chk("pulse width", v[6:0], d);
            d = $urandom;
            e = d[7:0];
            wr(OFF_WRITE_DATA, d, r);
            rd(OFF_WRITE_DATA, d, r);
            chk("write data rd", {24'h0, e}, d);
            chk("write data out", e, isp_write_data_out);
        end
        rd(8'h10, d, r);
        chk("unmapped", RESP_SLVERR, r);
        wr(8'h10, 32'h0000_0000, r);
        chk("unmapped wr", RESP_SLVERR, r);
        flash_busy <= 1'b1;
        cyc(3);
        chk("fetch block", 1, flash_fetch_block);
        flash_busy <= 1'b0;
        mass_erase_cmd <= 1'b1;
        cyc(3);
        chk("security gate", 1, security_clear_allowed);
        mass_erase_cmd <= 1'b0;
        tdone("registers");
        for (k = 0; k < 4; k++) begin
            wr(OFF_UNLOCK_CODE, {24'h0, UNLOCK_KEY, 2'(k)}, r);
            rd(OFF_STATUS, d, r);
            chk("unlock set", 1, d[ST_UNLOCK]);
            jump(1'b1);
            @(posedge aclk) return_to_flash_instr <= 1'b1;
            @(posedge aclk) return_to_flash_instr <= 1'b0;
            cyc(12);
            jump(1'b0);
        end
        wr(OFF_UNLOCK_CODE, {24'h0, UNLOCK_KEY ^ 6'h01, 2'h0}, r);
        rd(OFF_STATUS, d, r);
        chk("bad key", 0, d[ST_UNLOCK]);
        jump(1'b0);
        wr(OFF_UNLOCK_CODE, {24'h0, UNLOCK_KEY, 2'h0}, r);
        emulation_mode <= 1'b1;
        breakpoint_hit <= 1'b1;
        cyc(12);
        rd(OFF_STATUS, d, r);
        chk("frozen", 1, d[ST_UNLOCK]);
        breakpoint_hit <= 1'b0;
        cyc(12);
        rd(OFF_STATUS, d, r);
        chk("expired", 0, d[ST_UNLOCK]);
        emulation_mode <= 1'b0;
        tdone("unlock");
        do_reset(1'b1);
        #1;
        chk("pin reads one", 1, forced_boot_pin_read);
        chk("load clock oe", 1, serial_clock_oe);
        cyc(2);
        #1;
        chk("load clock", 1, serial_clock_out);
        rd(OFF_STATUS, d, r);
        chk("forced boot", 3'b110, d[ST_FORCED:ST_UNLOCK]);
        for (k = 0; k < 60 && isp_cmd_enable !== 1'b1; k++) cyc(1);
        chk("cmd enable", 1, isp_cmd_enable);
        chk("debounce wait", 1, k >= DEB);
        do_reset(1'b0);
        rd(OFF_STATUS, d, r);
        chk("plain reset", 0, d[ST_BOOT_ROM]);
        boot_select <= 1'b0;
        do_reset(1'b0);
        rd(OFF_STATUS, d, r);
        chk("rom start", 1, d[ST_BOOT_ROM]);
        tdone("forced");
        finish_test();
    end
endmodule
`default_nettype wire
